// *** drg_defs.vh ***
`ifndef DRG_DEFS_VH
`define DRG_DEFS_VH

// ********
// Register map (byte addresses, one aligned word each)
// ********
`define DRG_OFS_CTRL      4'h0
`define DRG_OFS_COUNT     4'h4
`define DRG_OFS_STATUS    4'h8

// ********
// Control fields
// ********
`define DRG_TYPE_BIT      2
`define DRG_RATE_LSB      3
`define DRG_RATE_MSB      4
`define DRG_TYPE_RST      1'b0
`define DRG_RATE_RST      2'h0
`define DRG_RATE_32       2'h0
`define DRG_RATE_64       2'h1
`define DRG_RATE_RSVD     2'h2
`define DRG_RATE_OFF      2'h3

// ********
// Status fields
// ********
`define DRG_ST_BUSY       0
`define DRG_ST_PEND       1
`define DRG_ST_TR         2

// ********
// Refresh counter layout and interval terminal counts
// ********
`define DRG_CNT_RST       14'h0000
`define DRG_INT_ZERO      6'h00
`define DRG_INT_TERM_32   6'h1F
`define DRG_INT_TERM_64   6'h3F
`define DRG_ROW_STEP      8'h01
`define DRG_CNT_STEP      14'h0001

// ********
// Bus constants
// ********
`define DRG_RESP_OKAY     2'h0
`define DRG_RESP_SLVERR   2'h2
`define DRG_ZERO32        32'h00000000
`define DRG_ZERO16        16'h0000
`define DRG_ZERO8         8'h00

`endif

// *** drg_refresh_counter.v ***
`timescale 1ns/100ps
`include "drg_defs.vh"

module drg_refresh_counter (
    input  wire        clk_sys,    // System clock
    input  wire        reset_n,    // Synchronous reset, active low
    input  wire [1:0]  rate,       // Refresh rate code
    input  wire        wr_lo,      // Software write of count bits 7:2
    input  wire        wr_hi,      // Software write of count bits 15:8
    input  wire [15:0] wr_data,    // Software write data
    output wire [15:0] count,      // Counter image, bits 1:0 read zero
    output reg         req_q,      // One-cycle refresh request
    output reg  [7:0]  req_row_q   // Row address captured with request
);

    reg  [13:0] cnt_q;
    reg  [13:0] cnt_d;
    wire [5:0]  intvl = cnt_q[5:0];
    wire [7:0]  row   = cnt_q[13:6];
    wire [5:0]  term  = (rate == `DRG_RATE_32) ? `DRG_INT_TERM_32 : `DRG_INT_TERM_64;
    wire        wrap  = (intvl == term);
    wire        en    = (rate == `DRG_RATE_32) || (rate == `DRG_RATE_64);

    assign count = {cnt_q, 2'b00};

    // ********
    // Interval and row form one carry chain; the interval is cut
    // short at the terminal count so every request moves the row
    // ********
    always @* begin
        if (wrap) begin
            cnt_d = {row + `DRG_ROW_STEP, `DRG_INT_ZERO};
        end else begin
            cnt_d = cnt_q + `DRG_CNT_STEP;
        end
        if (wr_lo) begin
            cnt_d[5:0] = wr_data[7:2];
        end
        if (wr_hi) begin
            cnt_d[13:6] = wr_data[15:8];
        end
    end

    always @(posedge clk_sys) begin
        if (!reset_n) begin
            cnt_q     <= `DRG_CNT_RST;
            req_q     <= 1'b0;
            req_row_q <= `DRG_ZERO8;
        end else begin
            cnt_q <= cnt_d;
            req_q <= wrap && en && !wr_lo && !wr_hi;
            if (wrap) begin
                req_row_q <= row;
            end
        end
    end

endmodule

// *** drg_refresh_gen.v ***
// Operation
// - Refresh cycles run by themselves at a programmed interval; software can stop them.
// - Type select 0 gives RAS-only cycles, 1 gives CAS-before-RAS cycles.
// - Rate 00 refreshes every 32 clocks, 01 every 64, 11 none, 10 reserved.
// - Reset forces type select to 0 and rate field to 00.
// - No refresh while reset is held; periodic refresh starts after release.
// - Same valid 8-bit row address is output for both refresh types.
// - Count bits 2 to 15 are one counter: 2-7 interval, 8-15 row.
// - Row field appears on bus lines 0-7 when the row strobe falls.
// - Seven low row bits also appear on bus lines 8-14.
// - Refresh flag on top bus line is low as the row strobe falls.
// - Refresh flag is valid before the row strobe falls.
// - Transfer/output enable low before row strobe fall marks a transfer cycle.
// - Transfer flag at column time repeats transfer enable level sampled at row fall.
// - In CAS-before-RAS refresh the column strobe falls before the row strobe.
// - Row address walks through all 256 values over successive refreshes.
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/100ps
`include "drg_defs.vh"

module drg_refresh_gen (
    input  wire        clk_sys,        // System clock, 10 MHz
    input  wire        reset_n,        // Synchronous reset, active low
    // AXI4-Lite slave
    input  wire [3:0]  s_axi_awaddr,   // Write address
    input  wire        s_axi_awvalid,  // Write address valid
    output wire        s_axi_awready,  // Write address ready
    input  wire [31:0] s_axi_wdata,    // Write data
    input  wire [3:0]  s_axi_wstrb,    // Write byte strobes
    input  wire        s_axi_wvalid,   // Write data valid
    output wire        s_axi_wready,   // Write data ready
    output reg  [1:0]  s_axi_bresp,    // Write response
    output reg         s_axi_bvalid,   // Write response valid
    input  wire        s_axi_bready,   // Write response ready
    input  wire [3:0]  s_axi_araddr,   // Read address
    input  wire        s_axi_arvalid,  // Read address valid
    output wire        s_axi_arready,  // Read address ready
    output reg  [31:0] s_axi_rdata,    // Read data
    output reg  [1:0]  s_axi_rresp,    // Read response
    output reg         s_axi_rvalid,   // Read data valid
    input  wire        s_axi_rready,   // Read data ready
    // Shift-register-transfer requests
    input  wire        xfer_req,       // Transfer cycle wanted, level
    input  wire [14:0] xfer_row,       // Row-time bus value for transfer
    input  wire [13:0] xfer_col,       // Column-time address for transfer
    output reg         xfer_ack_q,     // Transfer cycle finished, pulse
    // Memory bus
    output reg  [15:0] muxed_addr_data_bus, // Multiplexed bus output value
    output reg         bus_oe_n,       // Bus output enable, low while driving
    output reg         ras_n,          // Row strobe, active low
    output reg         cas_n,          // Column strobe, active low
    output reg         transfer_output_enable // Transfer/output enable, active low
);

    // ****************************************************************
    // Cycle states
    // ****************************************************************
    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_ADDR = 6'h02;
    localparam [5:0] ST_RAS  = 6'h04;
    localparam [5:0] ST_COL  = 6'h08;
    localparam [5:0] ST_CAS  = 6'h10;
    localparam [5:0] ST_PRE  = 6'h20;

    // ****************************************************************
    // Control register
    // ****************************************************************
    reg        refresh_type_select_q;
    reg  [1:0] refresh_rate_field_q;

    // ****************************************************************
    // Bus slave state
    // ****************************************************************
    reg        aw_held_q;
    reg  [3:0] aw_addr_q;
    reg        w_held_q;
    reg [31:0] w_data_q;
    reg  [3:0] w_strb_q;

    wire       aw_take   = s_axi_awvalid && s_axi_awready;
    wire       w_take    = s_axi_wvalid && s_axi_wready;
    wire       aw_have   = aw_held_q || aw_take;
    wire       w_have    = w_held_q || w_take;
    wire [3:0] wr_addr   = aw_held_q ? aw_addr_q : s_axi_awaddr;
    wire [31:0] wr_data  = w_held_q ? w_data_q : s_axi_wdata;
    wire [3:0] wr_strb   = w_held_q ? w_strb_q : s_axi_wstrb;
    wire       wr_fire   = aw_have && w_have && !s_axi_bvalid;

    // Ready stays low once a channel is held, so each write is one beat
    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    wire wr_ctrl  = wr_fire && (wr_addr == `DRG_OFS_CTRL);
    wire wr_count = wr_fire && (wr_addr == `DRG_OFS_COUNT);
    wire wr_known = wr_ctrl || wr_count || (wr_addr == `DRG_OFS_STATUS);

    // ****************************************************************
    // Refresh counter
    // ****************************************************************
    wire [15:0] count;
    wire        ref_req;
    wire [7:0]  ref_row;

    drg_refresh_counter u_counter (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .rate      (refresh_rate_field_q),
        .wr_lo     (wr_count && wr_strb[0]),
        .wr_hi     (wr_count && wr_strb[1]),
        .wr_data   (wr_data[15:0]),
        .count     (count),
        .req_q     (ref_req),
        .req_row_q (ref_row)
    );

    // ****************************************************************
    // Cycle engine state
    // ****************************************************************
    reg  [5:0] state_q;
    reg  [5:0] state_d;
    reg        pend_q;
    reg  [7:0] pend_row_q;
    reg        is_ref_q;
    reg        is_ref_d;
    reg        cbr_q;
    reg        cbr_d;
    reg        tr_seen_q;
    reg        tr_seen_d;
    reg [15:0] bus_d;
    reg        oe_n_d;
    reg        ras_n_d;
    reg        cas_n_d;
    reg        tr_oe_n_d;
    reg        ack_d;

    wire start_ref = (state_q == ST_IDLE) && pend_q;
    wire start_xfr = (state_q == ST_IDLE) && !pend_q && xfer_req;

    // ****************************************************************
    // Register writes
    // ****************************************************************
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            refresh_type_select_q <= `DRG_TYPE_RST;
            refresh_rate_field_q  <= `DRG_RATE_RST;
            aw_held_q             <= 1'b0;
            aw_addr_q             <= 4'h0;
            w_held_q              <= 1'b0;
            w_data_q              <= `DRG_ZERO32;
            w_strb_q              <= 4'h0;
            s_axi_bvalid          <= 1'b0;
            s_axi_bresp           <= `DRG_RESP_OKAY;
        end else begin
            if (aw_take && !wr_fire) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_take && !wr_fire) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? `DRG_RESP_OKAY : `DRG_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_ctrl && wr_strb[0]) begin
                refresh_type_select_q <= wr_data[`DRG_TYPE_BIT];
                refresh_rate_field_q  <= wr_data[`DRG_RATE_MSB:`DRG_RATE_LSB];
            end
        end
    end

    // ****************************************************************
    // Register reads
    // ****************************************************************
    reg [31:0] rd_val;
    reg        rd_ok;

    always @* begin
        rd_val = `DRG_ZERO32;
        rd_ok  = 1'b1;
        case (s_axi_araddr)
            `DRG_OFS_CTRL: begin
                rd_val[`DRG_TYPE_BIT]                = refresh_type_select_q;
                rd_val[`DRG_RATE_MSB:`DRG_RATE_LSB]  = refresh_rate_field_q;
            end
            `DRG_OFS_COUNT: begin
                rd_val[15:0] = count;
            end
            `DRG_OFS_STATUS: begin
                rd_val[`DRG_ST_BUSY] = (state_q != ST_IDLE);
                rd_val[`DRG_ST_PEND] = pend_q;
                rd_val[`DRG_ST_TR]   = tr_seen_q;
            end
            default: begin
                rd_ok = 1'b0;
            end
        endcase
    end

    always @(posedge clk_sys) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= `DRG_ZERO32;
            s_axi_rresp  <= `DRG_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_ok ? `DRG_RESP_OKAY : `DRG_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // Memory cycle sequencer
    // Refresh outranks transfers; a transfer waits at most one
    // refresh cycle because a new request takes at least 32 clocks to come
    // ****************************************************************
    always @* begin
        state_d   = state_q;
        is_ref_d  = is_ref_q;
        cbr_d     = cbr_q;
        tr_seen_d = tr_seen_q;
        bus_d     = muxed_addr_data_bus;
        oe_n_d    = bus_oe_n;
        ras_n_d   = ras_n;
        cas_n_d   = cas_n;
        tr_oe_n_d = transfer_output_enable;
        ack_d     = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (start_ref) begin
                    // Row field on 7:0, its low seven bits again on 14:8, flag low
                    bus_d     = {1'b0, pend_row_q[6:0], pend_row_q};
                    oe_n_d    = 1'b0;
                    is_ref_d  = 1'b1;
                    cbr_d     = refresh_type_select_q;
                    cas_n_d   = !refresh_type_select_q;
                    state_d   = ST_ADDR;
                end else if (start_xfr) begin
                    bus_d     = {1'b1, xfer_row};
                    oe_n_d    = 1'b0;
                    is_ref_d  = 1'b0;
                    cbr_d     = 1'b0;
                    tr_oe_n_d = 1'b0;
                    state_d   = ST_ADDR;
                end
            end
            ST_ADDR: begin
                ras_n_d = 1'b0;
                state_d = ST_RAS;
            end
            ST_RAS: begin
                tr_seen_d = !transfer_output_enable;
                if (is_ref_q) begin
                    ras_n_d = 1'b1;
                    cas_n_d = 1'b1;
                    oe_n_d  = 1'b1;
                    state_d = ST_PRE;
                end else begin
                    // Level held through the row fall is repeated as the flag
                    bus_d     = {1'b0, transfer_output_enable, xfer_col};
                    tr_oe_n_d = 1'b1;
                    state_d   = ST_COL;
                end
            end
            ST_COL: begin
                cas_n_d = 1'b0;
                state_d = ST_CAS;
            end
            ST_CAS: begin
                ras_n_d = 1'b1;
                cas_n_d = 1'b1;
                oe_n_d  = 1'b1;
                ack_d   = 1'b1;
                state_d = ST_PRE;
            end
            ST_PRE: begin
                state_d = ST_IDLE;
            end
            default: begin
                ras_n_d   = 1'b1;
                cas_n_d   = 1'b1;
                oe_n_d    = 1'b1;
                tr_oe_n_d = 1'b1;
                state_d   = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_sys) begin
        if (!reset_n) begin
            state_q                <= ST_IDLE;
            pend_q                 <= 1'b0;
            pend_row_q             <= `DRG_ZERO8;
            is_ref_q               <= 1'b0;
            cbr_q                  <= 1'b0;
            tr_seen_q              <= 1'b0;
            muxed_addr_data_bus    <= `DRG_ZERO16;
            bus_oe_n               <= 1'b1;
            ras_n                  <= 1'b1;
            cas_n                  <= 1'b1;
            transfer_output_enable <= 1'b1;
            xfer_ack_q             <= 1'b0;
        end else begin
            // A request landing as a cycle starts stays pending
            pend_q                 <= ref_req || (pend_q && !start_ref);
            if (ref_req) begin
                pend_row_q <= ref_row;
            end
            state_q                <= state_d;
            is_ref_q               <= is_ref_d;
            cbr_q                  <= cbr_d;
            tr_seen_q              <= tr_seen_d;
            muxed_addr_data_bus    <= bus_d;
            bus_oe_n               <= oe_n_d;
            ras_n                  <= ras_n_d;
            cas_n                  <= cas_n_d;
            transfer_output_enable <= tr_oe_n_d;
            xfer_ack_q             <= ack_d;
        end
    end

endmodule

// *** drg_refresh_gen_props.sv ***
`timescale 1ns/100ps
// ********
// Strobe and bus status checks
// ********
module drg_refresh_gen_props (
    input wire        clk_sys,                // Clock
    input wire        reset_n,                // Reset, active low
    input wire        s_axi_arvalid,          // Read address valid
    input wire        s_axi_arready,          // Read address ready
    input wire        s_axi_rvalid,           // Read data valid
    input wire        s_axi_bvalid,           // Write response valid
    input wire        s_axi_bready,           // Write response ready
    input wire [1:0]  s_axi_bresp,            // Write response
    input wire [15:0] muxed_addr_data_bus,    // Bus value
    input wire        bus_oe_n,               // Bus enable, active low
    input wire        ras_n,                  // Row strobe
    input wire        cas_n,                  // Column strobe
    input wire        transfer_output_enable  // Transfer enable, active low
);
    reg toe_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Frozen while the row strobe is low
    always @(posedge clk_sys) begin
        if (ras_n)
            toe_q <= transfer_output_enable;
    end
    sequence s_ras_fall;
        $fell(ras_n);
    endsequence
    sequence s_idle;
        ras_n && cas_n && bus_oe_n;
    endsequence
    a_rf_marks_cycle: assert property (s_ras_fall |-> muxed_addr_data_bus[15] == !transfer_output_enable)
        else $error("bad cycle flag");
    a_row_mirror: assert property (s_ras_fall ##0 !muxed_addr_data_bus[15] |-> muxed_addr_data_bus[14:8] == muxed_addr_data_bus[6:0])
        else $error("bad row copy");
    a_status_early: assert property (s_ras_fall |-> !$past(bus_oe_n) && $stable(muxed_addr_data_bus))
        else $error("bus late");
    a_cbr_order: assert property (s_ras_fall ##0 !cas_n |-> $past(cas_n) == 1'b0)
        else $error("column strobe late");
    a_tr_repeat: assert property ($fell(cas_n) && !ras_n |-> muxed_addr_data_bus[14] == toe_q)
        else $error("bad transfer flag");
    a_reset_quiet: assert property ($rose(reset_n) |-> s_idle)
        else $error("strobes active");
    a_first_refresh: assert property ($rose(reset_n) |-> ##[20:40] s_ras_fall)
        else $error("no refresh");
    a_cycle_ends: assert property (s_ras_fall |-> ##[1:3] s_idle)
        else $error("cycle hung");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read late");
    a_wr_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("response dropped");
endmodule

bind drg_refresh_gen drg_refresh_gen_props i_props (.clk_sys, .reset_n, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .muxed_addr_data_bus, .bus_oe_n, .ras_n, .cas_n, .transfer_output_enable);

// *** drg_mem_model.sv ***
`timescale 1ns/100ps
// ********
// Memory array with strobe decode
// ********
module drg_mem_model (
    input  wire        clk_sys,           // Clock
    input  wire [15:0] bus,               // Multiplexed bus
    input  wire        ras_n,             // Row strobe
    input  wire        cas_n,             // Column strobe
    input  wire        toe_n,             // Transfer/output enable
    output wire        ras_all_n,         // Row strobe broadcast to every part
    output wire        ro_cas_n,          // Column strobe to RAS-only parts
    output wire        vram_cas_n,        // Column strobe broadcast to VRAMs
    output reg  [7:0]  row_q = 8'h00,     // Last refreshed row
    output reg         cbr_q = 1'b0,      // Last refresh had early column strobe
    output reg  [15:0] cnt_q = 16'h0000   // Refreshes seen
);
    reg ras_q = 1'b1;
    reg bc_q  = 1'b0;
    assign ras_all_n  = ras_n | ~bc_q;
    // RAS-only parts never see a column strobe ahead of the row strobe
    assign ro_cas_n   = cas_n | ras_n;
    assign vram_cas_n = cas_n | ras_n | bus[14];
    always @(posedge clk_sys) begin
        ras_q <= ras_n;
        if (ras_n)
            bc_q <= ~bus[15] | ~toe_n;
        if (ras_q && !ras_n && !bus[15]) begin
            row_q <= bus[7:0];
            cbr_q <= ~cas_n;
            cnt_q <= cnt_q + 16'h0001;
        end
    end
endmodule

// *** drg_refresh_gen_tb_top.sv ***
`timescale 1ns/100ps
`include "drg_defs.vh"
module drg_refresh_gen_tb_top;
    // ********
    // Stimulus, monitor and verdict
    // ********
    reg         clk_sys = 1'b0;
    reg         reset_n = 1'b0;
    reg  [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    reg  [31:0] s_axi_wdata = 32'h0, rd, r;
    reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, xfer_req = 1'b0;
    reg  [14:0] xfer_row = 15'h0;
    reg  [13:0] xfer_col = 14'h0;
    reg         gap_vld = 1'b0, row_vld = 1'b1, type_q = 1'b0, ras_q = 1'b1, cas_q = 1'b1;
    reg  [7:0]  exp_row = 8'h00, m_row;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire        xfer_ack_q, bus_oe_n, ras_n, cas_n, transfer_output_enable, m_cbr;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [15:0] muxed_addr_data_bus, m_cnt;
    integer     mismatches = 0, n_tests = 0, cyc = 0, last_cyc = 0, wr_cyc = 0, exp_gap = 32;
    integer     i, n0, seed = 32'hFDDF543F;

    drg_refresh_gen i_dut (.clk_sys, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .xfer_req, .xfer_row, .xfer_col, .xfer_ack_q,
        .muxed_addr_data_bus, .bus_oe_n, .ras_n, .cas_n, .transfer_output_enable);
    drg_mem_model i_mem (.clk_sys, .bus(muxed_addr_data_bus), .ras_n, .cas_n,
        .toe_n(transfer_output_enable), .ras_all_n(), .ro_cas_n(), .vram_cas_n(),
        .row_q(m_row), .cbr_q(m_cbr), .cnt_q(m_cnt));

    always #50 clk_sys = ~clk_sys;

    task chk(input ok, input string msg);
        begin
            n_tests = n_tests + 1;
            if (ok !== 1'b1) begin
                mismatches = mismatches + 1;
                $display("[ERR] %0t %0s", $time, msg);
            end
        end
    endtask
    task results;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, mismatches);
            if (mismatches == 0 && n_tests > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    task axi_wr(input [3:0] a, input [31:0] d, input [1:0] er);
        reg done;
        begin
            done = 1'b0;
            @(posedge clk_sys);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            while (!done) begin
                @(posedge clk_sys);
                if (s_axi_awvalid && s_axi_awready)
                    s_axi_awvalid <= 1'b0;
                if (s_axi_wvalid && s_axi_wready)
                    s_axi_wvalid <= 1'b0;
                if (s_axi_bvalid === 1'b1) begin
                    done = 1'b1;
                    s_axi_bready <= 1'b0;
                    chk(s_axi_bresp === er, "write response");
                end
            end
        end
    endtask
    task axi_rd(input [3:0] a, input [1:0] er);
        reg done;
        begin
            done = 1'b0;
            @(posedge clk_sys);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            while (!done) begin
                @(posedge clk_sys);
                if (s_axi_arvalid && s_axi_arready)
                    s_axi_arvalid <= 1'b0;
                if (s_axi_rvalid === 1'b1) begin
                    done = 1'b1;
                    rd = s_axi_rdata;
                    s_axi_rready <= 1'b0;
                    chk(s_axi_rresp === er, "read response");
                end
            end
        end
    endtask
    // A cycle already started keeps the old type
    task set_ctrl(input [31:0] d);
        begin
            axi_wr(`DRG_OFS_CTRL, d, `DRG_RESP_OKAY);
            type_q = d[`DRG_TYPE_BIT];
            wr_cyc = cyc;
            gap_vld = 1'b0;
        end
    endtask

    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            mismatches = mismatches + 1;
            results;
        end
        ras_q <= ras_n;
        cas_q <= cas_n;
        if (reset_n && ras_q && !ras_n && !muxed_addr_data_bus[15]) begin
            chk(muxed_addr_data_bus[14:8] === muxed_addr_data_bus[6:0], "row copy");
            if (row_vld)
                chk(muxed_addr_data_bus[7:0] === exp_row, "row sequence");
            if (gap_vld && last_cyc > wr_cyc)
                chk(cyc - last_cyc == exp_gap, "refresh gap");
            if (cyc - wr_cyc > 4)
                chk(cas_n === ~type_q, "refresh type");
            exp_row <= muxed_addr_data_bus[7:0] + 8'h01;
            row_vld <= 1'b1;
            gap_vld <= 1'b1;
            last_cyc <= cyc;
        end
        if (reset_n && ras_q && !ras_n && !transfer_output_enable)
            chk(muxed_addr_data_bus === {1'b1, xfer_row}, "transfer row");
        if (reset_n && cas_q && !cas_n && !ras_n)
            chk(muxed_addr_data_bus[14:0] === {1'b0, xfer_col}, "transfer column");
    end

    initial begin
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        axi_rd(`DRG_OFS_CTRL, `DRG_RESP_OKAY);
        chk(rd[4:2] === 3'h0, "control reset");
        axi_rd(4'hC, `DRG_RESP_SLVERR);
        chk(rd === 32'h0, "unmapped read");
        axi_wr(4'hC, 32'hFFFFFFFF, `DRG_RESP_SLVERR);
        repeat (200) @(posedge clk_sys);
        chk(m_cnt > 16'h0004, "refresh running");
        $display("rate 32 done");
        set_ctrl(32'h00000004);
        repeat (100) @(posedge clk_sys);
        chk(m_cbr === 1'b1, "early column strobe");
        axi_rd(`DRG_OFS_CTRL, `DRG_RESP_OKAY);
        chk(rd[4:2] === 3'h1, "control readback");
        set_ctrl(32'h00000008);
        exp_gap = 64;
        repeat (200) @(posedge clk_sys);
        chk(m_cbr === 1'b0, "row only refresh");
        $display("type and rate 64 done");
        for (i = 3; i >= 2; i = i - 1) begin
            set_ctrl(i << 3);
            row_vld = 1'b0;
            repeat (10) @(posedge clk_sys);
            n0 = m_cnt;
            repeat (150) @(posedge clk_sys);
            chk(m_cnt === n0[15:0], "refresh stopped");
        end
        for (i = 0; i < 2; i = i + 1) begin
            r = $random(seed);
            @(posedge clk_sys);
            xfer_row <= r[14:0];
            xfer_col <= r[30:17];
            xfer_req <= 1'b1;
            n0 = 0;
            while (n0 < 100 && xfer_ack_q !== 1'b1) begin
                @(posedge clk_sys);
                n0 = n0 + 1;
            end
            xfer_req <= 1'b0;
            chk(n0 < 100, "transfer finished");
        end
        axi_rd(`DRG_OFS_STATUS, `DRG_RESP_OKAY);
        chk(rd[`DRG_ST_TR] === 1'b1, "transfer status");
        $display("off and transfer done");
        for (i = 0; i < 3; i = i + 1) begin
            set_ctrl(32'h00000018);
            repeat (10) @(posedge clk_sys);
            r = $random(seed);
            axi_wr(`DRG_OFS_COUNT, {16'h0, r[7:0], 8'h00}, `DRG_RESP_OKAY);
            axi_rd(`DRG_OFS_COUNT, `DRG_RESP_OKAY);
            chk(rd[15:8] === r[7:0] && rd[1:0] === 2'h0, "count readback");
            exp_row = r[7:0];
            row_vld = 1'b1;
            exp_gap = 32;
            set_ctrl(32'h00000000);
            repeat (40) @(posedge clk_sys);
            chk(m_row === r[7:0], "row from counter");
        end
        $display("counter done");
        results;
    end
endmodule
